// ### clk_ctrl_consts.vh
// clk_ctrl_consts.vh: constants for the oscillator select and system clock
// control block; assumes a 25 MHz ref_clk and software-driven control ports.
// How it works
// - each oscillator has its own enable bit
// - software picks any oscillator as system clock
// - slow rc enabled after boot, fast rc too unless directive 6
// - trim register adjusts fast rc frequency
// - 34h/14h/3Ch give fast rc div 2/4/8
// - 1Ch and 7Ch give fast rc div 16/32
// - E4h selects slow rc undivided
// - calibrated boot loads mode, watchdog off, pin input
// - calibration disabled leaves mode and trim unchanged
// - calibration result kept, never rerun at boot
// - held in reset, then fast or normal delay
// - normal delay 55 ms, fast delay 820 us
// - clock follows new mode write at the end of a high phase
`ifndef CLK_CTRL_CONSTS_VH
`define CLK_CTRL_CONSTS_VH

// ----------------------------------------
// enable bit positions
// ----------------------------------------
`define XTAL_EN_BIT      7
`define FAST_RC_EN_BIT   4
`define SLOW_RC_EN_BIT   2

// ----------------------------------------
// clock mode encodings
// ----------------------------------------
`define MODE_FAST_DIV2   8'h34
`define MODE_FAST_DIV4   8'h14
`define MODE_FAST_DIV8   8'h3C
`define MODE_FAST_DIV16  8'h1C
`define MODE_FAST_DIV32  8'h7C
`define MODE_SLOW_DIV1   8'hE4
`define MODE_XTAL_DIV1   8'hB4

// ----------------------------------------
// reset values
// ----------------------------------------
`define MODE_RESET       8'hF4
`define XTAL_CTRL_RESET  8'h00
`define TRIM_RESET       8'h80

// ----------------------------------------
// boot delay (times in ns, 25 MHz clock)
// ----------------------------------------
`define CLK_PERIOD_NS    40
`define BOOT_NORMAL_NS   55000000
`define BOOT_FAST_NS     820000
`define BOOT_NORMAL_CYC  (`BOOT_NORMAL_NS / `CLK_PERIOD_NS)
`define BOOT_FAST_CYC    (`BOOT_FAST_NS / `CLK_PERIOD_NS)

`endif

// ### osc_select_sysclk_ctrl.v
// osc_select_sysclk_ctrl.v: boot sequencer, oscillator enables and glitch
// free system clock selection; oscillator clocks arrive as pins and are
// sampled into ref_clk, which must be faster than any of them.
`timescale 1ns/1ps
`include "clk_ctrl_consts.vh"

module osc_select_sysclk_ctrl #(
    parameter [31:0] BOOT_NORMAL_CYCLES = `BOOT_NORMAL_CYC,
    parameter [31:0] BOOT_FAST_CYCLES   = `BOOT_FAST_CYC
) (
    input  wire       ref_clk,
    input  wire       rst_b,
    input  wire       fast_boot_sel,
    input  wire [2:0] calibration_directive,
    input  wire [7:0] cal_trim_value,
    input  wire       mode_wr,
    input  wire [7:0] mode_wdata,
    input  wire       xtal_ctrl_wr,
    input  wire [7:0] xtal_ctrl_wdata,
    input  wire       trim_wr,
    input  wire [7:0] trim_wdata,
    input  wire       external_crystal_osc,
    input  wire       fast_internal_rc,
    input  wire       slow_internal_rc,
    output reg        boot_done_ff,
    output reg  [7:0] mode_ff,
    output reg  [7:0] xtal_ctrl_ff,
    output reg  [7:0] trim_ff,
    output reg        xtal_run_ff,
    output reg        fast_rc_run_ff,
    output reg        slow_rc_run_ff,
    output reg        watchdog_en_ff,
    output reg        port_a_pin_five_oe_ff,
    output reg        sys_clk_ff,
    output reg  [1:0] src_sel_ff
);

// ----------------------------------------
// boot sequencer
// ----------------------------------------
localparam ST_RESET = 2'b00;
localparam ST_WAIT  = 2'b01;
localparam ST_RUN   = 2'b10;
// calibration_directive: 0 disabled, 1..5 fast div 2..32, 6 slow rc
localparam [2:0] CAL_OFF = 3'h0;

reg  [1:0]  state_ff;
reg  [1:0]  nxt_state;
reg  [31:0] boot_cnt_ff;
reg  [31:0] nxt_boot_cnt;
reg         fast_boot_ff;
reg  [7:0]  cal_mode;

always @*
begin
    case (calibration_directive)
        3'h1:    cal_mode = `MODE_FAST_DIV2;
        3'h2:    cal_mode = `MODE_FAST_DIV4;
        3'h3:    cal_mode = `MODE_FAST_DIV8;
        3'h4:    cal_mode = `MODE_FAST_DIV16;
        3'h5:    cal_mode = `MODE_FAST_DIV32;
        3'h6:    cal_mode = `MODE_SLOW_DIV1;
        default: cal_mode = mode_ff;
    endcase
end

always @*
begin
    nxt_state    = state_ff;
    nxt_boot_cnt = boot_cnt_ff;
    case (state_ff)
        ST_RESET:
        begin
            nxt_state    = ST_WAIT;
            nxt_boot_cnt = 32'h0000_0000;
        end
        ST_WAIT:
        begin
            nxt_boot_cnt = boot_cnt_ff + 32'h0000_0001;
            if (boot_cnt_ff >= (fast_boot_ff ? BOOT_FAST_CYCLES - 32'h1
                                : BOOT_NORMAL_CYCLES - 32'h1))
                nxt_state = ST_RUN;
        end
        ST_RUN:  nxt_state = ST_RUN;
        default: nxt_state = ST_RESET;
    endcase
end

always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        state_ff     <= ST_RESET;
        boot_cnt_ff  <= 32'h0000_0000;
        fast_boot_ff <= 1'b0;
        boot_done_ff <= 1'b0;
    end
    else
    begin
        state_ff     <= nxt_state;
        boot_cnt_ff  <= nxt_boot_cnt;
        if (state_ff == ST_RESET)
            fast_boot_ff <= fast_boot_sel;    // strap caught after release
        boot_done_ff <= (nxt_state == ST_RUN);
    end
end

wire boot_end = (state_ff == ST_WAIT) && (nxt_state == ST_RUN);

// ----------------------------------------
// control registers
// ----------------------------------------
// the trim value is taken from the programmed result each calibrated boot; no
// calibration runs on silicon, so an unchanged trim means uncalibrated
reg  [7:0]  nxt_mode;
reg  [7:0]  nxt_xtal_ctrl;
reg  [7:0]  nxt_trim;
reg         nxt_watchdog_en;
wire        cal_on = (calibration_directive != CAL_OFF);

// one next value per register keeps the forced enable bits in one place
always @*
begin
    nxt_mode        = mode_ff;
    nxt_xtal_ctrl   = xtal_ctrl_ff;
    nxt_trim        = trim_ff;
    nxt_watchdog_en = watchdog_en_ff;
    if (boot_end)
    begin
        if (cal_on)
        begin
            nxt_mode        = cal_mode;
            nxt_trim        = cal_trim_value;
            nxt_watchdog_en = 1'b0;
        end
        else
            nxt_mode = mode_ff;
        nxt_mode[`SLOW_RC_EN_BIT] = 1'b1;
        if (calibration_directive != 3'h6)
            nxt_mode[`FAST_RC_EN_BIT] = 1'b1;
    end
    else if (state_ff == ST_RUN)
    begin
        if (mode_wr)
            nxt_mode = mode_wdata;
        if (xtal_ctrl_wr)
            nxt_xtal_ctrl = xtal_ctrl_wdata;
        if (trim_wr)
            nxt_trim = trim_wdata;
    end
end

always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        mode_ff               <= `MODE_RESET;
        xtal_ctrl_ff          <= `XTAL_CTRL_RESET;
        trim_ff               <= `TRIM_RESET;
        watchdog_en_ff        <= 1'b1;
        port_a_pin_five_oe_ff <= 1'b0;
    end
    else
    begin
        mode_ff               <= nxt_mode;
        xtal_ctrl_ff          <= nxt_xtal_ctrl;
        trim_ff               <= nxt_trim;
        watchdog_en_ff        <= nxt_watchdog_en;
        port_a_pin_five_oe_ff <= 1'b0;
    end
end

// ----------------------------------------
// source decode
// ----------------------------------------
localparam [1:0] SRC_FAST = 2'd0;
localparam [1:0] SRC_SLOW = 2'd1;
localparam [1:0] SRC_XTAL = 2'd2;

reg [1:0] tgt_src;
reg [5:0] tgt_div;   // all-ones mask: source edges per half period minus one

always @*
begin
    tgt_src = SRC_FAST;
    tgt_div = 6'd0;
    case (mode_ff)
        `MODE_FAST_DIV2:  tgt_div = 6'd1;
        `MODE_FAST_DIV4:  tgt_div = 6'd3;
        `MODE_FAST_DIV8:  tgt_div = 6'd7;
        `MODE_FAST_DIV16: tgt_div = 6'd15;
        `MODE_FAST_DIV32: tgt_div = 6'd31;
        `MODE_SLOW_DIV1:  tgt_src = SRC_SLOW;
        `MODE_XTAL_DIV1:  tgt_src = SRC_XTAL;
        default:          tgt_src = SRC_SLOW;
    endcase
end

// ----------------------------------------
// oscillator run control
// ----------------------------------------
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        xtal_run_ff    <= 1'b0;
        fast_rc_run_ff <= 1'b0;
        slow_rc_run_ff <= 1'b0;
    end
    else
    begin
        // selected source kept alive even if its enable drops
        xtal_run_ff    <= xtal_ctrl_ff[`XTAL_EN_BIT] ||
                          (src_sel_ff == SRC_XTAL);
        fast_rc_run_ff <= mode_ff[`FAST_RC_EN_BIT] ||
                          (src_sel_ff == SRC_FAST);
        slow_rc_run_ff <= mode_ff[`SLOW_RC_EN_BIT] ||
                          (src_sel_ff == SRC_SLOW);
    end
end

// ----------------------------------------
// oscillator sampling and edge detect
// ----------------------------------------
reg [2:0] osc_s1_ff;
reg [2:0] osc_s2_ff;
reg [2:0] osc_s3_ff;

always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        osc_s1_ff <= 3'h0;
        osc_s2_ff <= 3'h0;
        osc_s3_ff <= 3'h0;
    end
    else
    begin
        osc_s1_ff <= {external_crystal_osc, slow_internal_rc,
                      fast_internal_rc};
        osc_s2_ff <= osc_s1_ff;
        osc_s3_ff <= osc_s2_ff;
    end
end

// both source edges count, so divide-by-one follows the source itself
wire [2:0] osc_edge = osc_s2_ff ^ osc_s3_ff;

// ----------------------------------------
// glitch free divider and switch
// ----------------------------------------
// output only toggles on source edges at divider wrap, and a switch waits
// for the end of a high phase so no runt high pulse is produced
reg  [5:0] div_cnt_ff;
reg  [5:0] div_ff;
reg  [5:0] nxt_div_cnt;
reg  [5:0] nxt_div;
reg  [1:0] nxt_src_sel;
reg        nxt_sys_clk;
wire       src_edge = osc_edge[src_sel_ff];
wire       wrap     = (div_cnt_ff >= div_ff);
wire       retarget = (tgt_src != src_sel_ff) || (tgt_div != div_ff);

always @*
begin
    nxt_div_cnt = div_cnt_ff;
    nxt_div     = div_ff;
    nxt_src_sel = src_sel_ff;
    nxt_sys_clk = sys_clk_ff;
    if (src_edge)
    begin
        if (wrap)
        begin
            nxt_div_cnt = 6'h00;
            if (sys_clk_ff && retarget)
            begin
                nxt_sys_clk = 1'b0;
                nxt_src_sel = tgt_src;
                nxt_div     = tgt_div;
            end
            else
                nxt_sys_clk = ~sys_clk_ff;
        end
        else
            nxt_div_cnt = div_cnt_ff + 6'h01;
    end
end

always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        div_cnt_ff <= 6'h00;
        div_ff     <= 6'h00;
        src_sel_ff <= SRC_SLOW;
        sys_clk_ff <= 1'b0;
    end
    else
    begin
        div_cnt_ff <= nxt_div_cnt;
        div_ff     <= nxt_div;
        src_sel_ff <= nxt_src_sel;
        sys_clk_ff <= nxt_sys_clk;
    end
end
// software keeps the old source enabled; run logic also holds it

endmodule // osc_select_sysclk_ctrl

// ### osc_select_sysclk_ctrl_sva.sv
// port assertions for the clock control block
// assumes strap and directive are held steady through boot
`timescale 1ns/1ps
`include "clk_ctrl_consts.vh"
module clk_ctrl_chk #(
    parameter [31:0] BOOT_NORMAL_CYCLES = 20,
    parameter [31:0] BOOT_FAST_CYCLES   = 5
) (
    input wire       ref_clk,
    input wire       rst_b,
    input wire       fast_boot_sel,
    input wire [2:0] calibration_directive,
    input wire [7:0] cal_trim_value,
    input wire       mode_wr,
    input wire [7:0] mode_wdata,
    input wire       boot_done_ff,
    input wire [7:0] mode_ff,
    input wire [7:0] xtal_ctrl_ff,
    input wire [7:0] trim_ff,
    input wire       fast_rc_run_ff,
    input wire       slow_rc_run_ff,
    input wire       watchdog_en_ff,
    input wire       port_a_pin_five_oe_ff,
    input wire [1:0] src_sel_ff
);
    // ----------------
    // boot counter
    // ----------------
    reg  [31:0] boot_cnt_ff;
    wire [31:0] want = fast_boot_sel ? BOOT_FAST_CYCLES : BOOT_NORMAL_CYCLES;
    wire        no_cal = calibration_directive == 3'h0;
    always @(posedge ref_clk)
    begin
        if (!rst_b)
            boot_cnt_ff <= 32'h0;
        else if (!boot_done_ff)
            boot_cnt_ff <= boot_cnt_ff + 32'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_rst;
        $rose(rst_b) |-> mode_ff == `MODE_RESET && trim_ff == `TRIM_RESET
            && xtal_ctrl_ff == `XTAL_CTRL_RESET && !boot_done_ff;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_oe;
        port_a_pin_five_oe_ff == 1'b0;
    endproperty
    a_oe: assert property (p_oe) else $error("pin driven");
    property p_wr;
        boot_done_ff && mode_wr |=> mode_ff == $past(mode_wdata);
    endproperty
    a_wr: assert property (p_wr) else $error("mode write");
    property p_hold;
        !boot_done_ff ##1 !boot_done_ff |-> $stable(mode_ff) && $stable(trim_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("write in boot");
    // tolerance of two covers the strap capture edge
    property p_len;
        $rose(boot_done_ff) |-> boot_cnt_ff + 32'h2 >= want
            && boot_cnt_ff <= want + 32'h2;
    endproperty
    a_len: assert property (p_len) else $error("boot length");
    property p_cal;
        $rose(boot_done_ff) |-> watchdog_en_ff == no_cal;
    endproperty
    a_cal: assert property (p_cal) else $error("watchdog");
    property p_trim;
        $rose(boot_done_ff) |-> trim_ff == (no_cal ? `TRIM_RESET : cal_trim_value);
    endproperty
    a_trim: assert property (p_trim) else $error("trim load");
    property p_fen;
        $past(boot_done_ff) |-> fast_rc_run_ff ==
            ($past(mode_ff[`FAST_RC_EN_BIT]) || $past(src_sel_ff) == 2'h0);
    endproperty
    a_fen: assert property (p_fen) else $error("fast run");
    property p_sen;
        $past(boot_done_ff) |-> slow_rc_run_ff ==
            ($past(mode_ff[`SLOW_RC_EN_BIT]) || $past(src_sel_ff) == 2'h1);
    endproperty
    a_sen: assert property (p_sen) else $error("slow run");
    c_fast: cover property ($rose(boot_done_ff) && fast_boot_sel);
    c_xtal: cover property (src_sel_ff == 2'h2);
    c_wr: cover property (boot_done_ff && mode_wr);
endmodule // clk_ctrl_chk

bind osc_select_sysclk_ctrl clk_ctrl_chk #(
    .BOOT_NORMAL_CYCLES(BOOT_NORMAL_CYCLES),
    .BOOT_FAST_CYCLES(BOOT_FAST_CYCLES)
) u_chk (.ref_clk, .rst_b, .fast_boot_sel, .calibration_directive,
    .cal_trim_value, .mode_wr, .mode_wdata, .boot_done_ff, .mode_ff,
    .xtal_ctrl_ff, .trim_ff, .fast_rc_run_ff, .slow_rc_run_ff,
    .watchdog_en_ff, .port_a_pin_five_oe_ff, .src_sel_ff);

// ### testbench.sv
// bench for boot options and clock switching
// drives every port; oscillators come from a ref_clk counter
`timescale 1ns/1ps
`include "clk_ctrl_consts.vh"
module testbench;
    localparam [63:0] MODES = {`MODE_FAST_DIV2, `MODE_FAST_DIV4,
        `MODE_FAST_DIV8, `MODE_FAST_DIV16, `MODE_FAST_DIV32, `MODE_RESET,
        `MODE_SLOW_DIV1, `MODE_XTAL_DIV1};
    reg        ref_clk = 1'b0;
    reg        rst_b = 1'b0;
    reg        fb = 1'b0;
    reg  [2:0] dir = 3'h0;
    reg  [7:0] ctrim = 8'h00;
    reg        m_wr = 1'b0;
    reg        x_wr = 1'b0;
    reg        t_wr = 1'b0;
    reg  [7:0] wd = 8'h00;
    reg  [4:0] osc = 5'h00;
    reg        last;
    wire       done, xr, fr, sr, wdog, oe, sck;
    wire [7:0] mode, xctl, trim;
    wire [1:0] src;
    integer    num_errors = 0;
    integer    cmp_count = 0;
    integer    i, d, r, t1, t2;

    osc_select_sysclk_ctrl #(.BOOT_NORMAL_CYCLES(40), .BOOT_FAST_CYCLES(12))
    u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .fast_boot_sel(fb),
        .calibration_directive(dir), .cal_trim_value(ctrim),
        .mode_wr(m_wr), .mode_wdata(wd), .xtal_ctrl_wr(x_wr),
        .xtal_ctrl_wdata(wd), .trim_wr(t_wr), .trim_wdata(wd),
        .external_crystal_osc(osc[3]), .fast_internal_rc(osc[2]),
        .slow_internal_rc(osc[4]), .boot_done_ff(done), .mode_ff(mode),
        .xtal_ctrl_ff(xctl), .trim_ff(trim), .xtal_run_ff(xr),
        .fast_rc_run_ff(fr), .slow_rc_run_ff(sr), .watchdog_en_ff(wdog),
        .port_a_pin_five_oe_ff(oe), .sys_clk_ff(sck), .src_sel_ff(src));

    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        osc <= osc + 5'h01;

    task chk(input [31:0] seen, input [31:0] exp, input string what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp)
            begin
                num_errors = num_errors + 1;
                $display("[FAIL] %s exp %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task wr(input [1:0] k, input [7:0] v);
        begin
            @(posedge ref_clk);
            m_wr <= k == 2'h0;
            x_wr <= k == 2'h1;
            t_wr <= k == 2'h2;
            wd <= v;
            @(posedge ref_clk);
            m_wr <= 1'b0;
            x_wr <= 1'b0;
            t_wr <= 1'b0;
            #1;
        end
    endtask
    task wait_cyc(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask
    task boot(input [2:0] v);
        begin
            @(posedge ref_clk);
            rst_b <= 1'b0;
            dir <= v;
            fb <= v[0];
            ctrim <= 8'h40 + {5'h00, v};
            wait_cyc(10);
            chk(mode, `MODE_RESET, "rst mode");
            chk(trim, `TRIM_RESET, "rst trim");
            chk(wdog, 1, "rst wdog");
            @(posedge ref_clk);
            rst_b <= 1'b1;
            // ignored: boot is still running
            wr(0, 8'h55);
            for (i = 0; i < 300 && done !== 1'b1; i = i + 1)
                @(posedge ref_clk);
            #1;
            chk(done, 1, "boot done");
        end
    endtask
    task sw(input [7:0] m, input [31:0] per, input [1:0] s);
        begin
            wr(0, m);
            chk(mode, m, "mode wr");
            r = 0;
            last = 1'b1;
            for (i = 0; i < 1500 && r < 3; i = i + 1)
            begin
                wait_cyc(1);
                if (sck === 1'b1 && last === 1'b0)
                begin
                    r = r + 1;
                    t1 = t2;
                    t2 = i;
                end
                last = sck;
            end
            chk(t2 - t1, per, "period");
            chk(r, 3, "rise count");
            chk(src, s, "source");
            chk(fr, m[4] || s == 2'h0, "fast run");
            chk(sr, m[2] || s == 2'h1, "slow run");
            $display("test mode %0h done", m);
        end
    endtask
    task final_report;
        begin
            $display("errors %0d compares %0d", num_errors, cmp_count);
            if (num_errors == 0 && cmp_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    initial
    begin
        for (d = 0; d < 7; d = d + 1)
        begin
            boot(d[2:0]);
            r = (d == 0) ? 5 : (d == 6) ? 6 : d - 1;
            chk(mode, MODES[63 - 8 * r -: 8], "boot mode");
            chk(trim, d ? 8'h40 + d : `TRIM_RESET, "boot trim");
            chk(wdog, d == 0, "boot wdog");
            chk(oe, 0, "pin dir");
            wait_cyc(3);
            chk(sr, 1, "slow on");
            chk(fr, d != 6, "fast on");
            $display("test boot %0d done", d);
        end
        wr(2, 8'hA5);
        chk(trim, 8'hA5, "trim wr");
        wr(1, 8'h80);
        chk(xctl, 8'h80, "xtal wr");
        $display("test write done");
        // table order keeps the running source enabled on each switch
        for (d = 0; d < 8; d = d + 1)
            sw(MODES[63 - 8 * d -: 8], d < 5 ? 16 << d : d < 7 ? 32 : 16,
                d < 5 ? 2'h0 : d < 7 ? 2'h1 : 2'h2);
        wr(1, 8'h00);
        wait_cyc(3);
        chk(xr, 1, "xtal kept");
        wr(1, 8'h80);
        sw(`MODE_FAST_DIV2, 16, 2'h0);
        wr(1, 8'h00);
        wait_cyc(3);
        chk(xr, 0, "xtal stop");
        $display("test stop done");
        final_report;
    end
    initial
    begin
        #2000000;
        num_errors = num_errors + 1;
        final_report;
    end
endmodule // testbench
